// [csrf_pkg.sv]
// Package for the configuration settings reply framer.
// Assumes one core clock; the framer takes its layout figures from here.
package csrf_pkg;

  // Reply shape
  localparam int unsigned MSG_BYTES = 3;
  localparam int unsigned MSG_COUNT = 23;
  localparam int unsigned REPLY_LEN = MSG_BYTES * MSG_COUNT;
  localparam logic [7:0] CMD_CODE = 8'h4B;
  localparam logic [7:0] MSG_TOTAL = 8'h17;

  // Byte offsets (zero based) of each field start and of the last byte, and field lengths
  localparam logic [6:0] OFS_STATUS = 7'h00;
  localparam logic [6:0] OFS_CMD = 7'h01;
  localparam logic [6:0] OFS_COUNT = 7'h02;
  localparam logic [6:0] OFS_WORDS = 7'h03;
  localparam logic [6:0] OFS_SEF_RATIO = 7'h23;
  localparam logic [6:0] OFS_NAME = 7'h25;
  localparam logic [6:0] OFS_OCI = 7'h34;
  localparam logic [6:0] OFS_RESID_RATIO = 7'h35;
  localparam logic [6:0] OFS_SPARE = 7'h37;
  localparam logic [6:0] OFS_CONTRAST = 7'h39;
  localparam logic [6:0] OFS_RELAY_PW = 7'h3B;
  localparam logic [6:0] OFS_TEST_PW = 7'h3F;
  localparam logic [6:0] OFS_CHECKSUM = 7'h43;
  localparam logic [6:0] OFS_LAST = 7'h44;
  localparam int unsigned WORD_COUNT = 16;
  localparam int unsigned NAME_LEN = 15;
  localparam int unsigned PW_LEN = 4;

  // Fill and reset values
  localparam logic [7:0] SPARE_FILL = 8'h00;
  localparam logic [15:0] SUM_RESET = 16'h0000;
  localparam logic [6:0] IDX_RESET = 7'h00;

  // Checksum selection
  localparam logic [1:0] CK_SUM = 2'h0;
  localparam logic [1:0] CK_XOR = 2'h1;

  // Flag word and button byte bit positions
  localparam int unsigned FLG_PROT_RMS = 0;
  localparam int unsigned FLG_PW_VIEW = 14;
  localparam int unsigned FLG_RESERVED = 11;
  localparam int unsigned OCI_CTRL_BTN = 0;
  localparam int unsigned OCI_BRKR_BTN = 1;

  // Settings image, in reply order
  typedef struct packed {
    logic [15:0] phaseCurrentTransformerRatio;
    logic [15:0] neutralCurrentTransformerRatio;
    logic [15:0] voltageTransformerRatio;
    logic [15:0] voltageTransformerConnection;
    logic [15:0] posSeqReactance;
    logic [15:0] posSeqResistance;
    logic [15:0] zeroSeqReactance;
    logic [15:0] zeroSeqResistance;
    logic [15:0] lineDistance;
    logic [15:0] tripFailTime;
    logic [15:0] closeFailTime;
    logic [15:0] phaseRotation;
    logic [15:0] configFlags;
    logic [15:0] alternateGroupOneEnable;
    logic [15:0] alternateGroupTwoEnable;
    logic [15:0] demandTimeConstant;
    logic [15:0] sefCurrentTransformerRatio;
    logic [NAME_LEN*8-1:0] unitName;
    logic [7:0] operatorControlInterfaceCfg;
    logic [15:0] residualVoltageTransformerRatio;
    logic [15:0] displayContrast;
    logic [PW_LEN*8-1:0] relayPassword;
    logic [PW_LEN*8-1:0] testPassword;
  } csrf_settings_t;

  // Outgoing byte stream
  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic first;
    logic last;
  } csrf_byte_t;

endpackage

// [csrf_checksum.sv]
// Running checksum over reply bytes.
// Assumes bytes arrive one per accepted beat, cleared at reply start.
`timescale 1ns/1ns
`default_nettype none
module csrf_checksum (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic [1:0] ckMode,
  input wire logic clear,
  input wire logic take,
  input wire logic [7:0] dataIn,
  // Result
  output logic [15:0] sum
);

  logic [15:0] sum_q;
  logic [15:0] sum_d;

  always_comb begin
    if (ckMode == csrf_pkg::CK_XOR) begin
      sum_d = sum_q ^ {8'h00, dataIn};
    end else begin
      sum_d = 16'(sum_q + {8'h00, dataIn});
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || clear) begin
      sum_q <= csrf_pkg::SUM_RESET;
    end else if (take) begin
      sum_q <= sum_d;
    end
  end

  assign sum = sum_q;

endmodule
`default_nettype wire

// [csrf_framer.sv]
// Configuration settings reply framer: serialises the 23 message reply.
// Assumes settings are held stable by the caller while a reply runs.
`timescale 1ns/1ns
`default_nettype none
module csrf_framer (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Request and status
  input wire logic startReq,
  input wire logic [7:0] relayStatus,
  input wire logic [1:0] ckMode,
  // Settings image
  input wire csrf_pkg::csrf_settings_t settings,
  // Byte stream out
  input wire logic txReady,
  output var csrf_pkg::csrf_byte_t txByte,
  output logic busy
);

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} csrf_state_t;

  csrf_state_t state_q;
  logic [6:0] idx_q;
  logic [6:0] idx_d;
  csrf_pkg::csrf_byte_t out_q;
  logic busy_q;
  logic [7:0] status_q;
  logic [7:0] curByte;
  logic [15:0] ckSum;
  logic beatTaken;
  logic [15:0] flagsClean;
  logic [7:0] ociClean;

  // Pick one byte of a field by position
  function automatic logic [7:0] wordByte(input logic [15:0] w, input logic lowHalf);
    return lowHalf ? w[7:0] : w[15:8];
  endfunction

  function automatic logic [7:0] strByte(input logic [119:0] s, input logic [6:0] pos,
                                         input logic [6:0] len);
    logic [6:0] sel;
    sel = 7'(len - 7'h01 - pos);
    return s[sel*8 +: 8];
  endfunction

  // Reserved bits are forced to zero so the host never sees stale values
  always_comb begin
    flagsClean = settings.configFlags;
    flagsClean[csrf_pkg::FLG_RESERVED] = 1'b0;
    flagsClean[15] = 1'b0;
    ociClean = {6'h00, settings.operatorControlInterfaceCfg[csrf_pkg::OCI_BRKR_BTN],
                settings.operatorControlInterfaceCfg[csrf_pkg::OCI_CTRL_BTN]};
  end

  // Byte selected by reply position
  always_comb begin
    logic [15:0] words [csrf_pkg::WORD_COUNT];
    logic [6:0] rel;
    for (int i = 0; i < csrf_pkg::WORD_COUNT; i++) begin
      words[i] = 16'h0000;
    end
    rel = 7'h00;
    words[0] = settings.phaseCurrentTransformerRatio;
    words[1] = settings.neutralCurrentTransformerRatio;
    words[2] = settings.voltageTransformerRatio;
    words[3] = settings.voltageTransformerConnection;
    words[4] = settings.posSeqReactance;
    words[5] = settings.posSeqResistance;
    words[6] = settings.zeroSeqReactance;
    words[7] = settings.zeroSeqResistance;
    words[8] = settings.lineDistance;
    words[9] = settings.tripFailTime;
    words[10] = settings.closeFailTime;
    words[11] = settings.phaseRotation;
    words[12] = flagsClean;
    words[13] = settings.alternateGroupOneEnable;
    words[14] = settings.alternateGroupTwoEnable;
    words[15] = settings.demandTimeConstant;
    curByte = csrf_pkg::SPARE_FILL;
    if (idx_q == csrf_pkg::OFS_STATUS) begin
      curByte = status_q;
    end else if (idx_q == csrf_pkg::OFS_CMD) begin
      curByte = csrf_pkg::CMD_CODE;
    end else if (idx_q == csrf_pkg::OFS_COUNT) begin
      curByte = csrf_pkg::MSG_TOTAL;
    end else if (idx_q < csrf_pkg::OFS_SEF_RATIO) begin
      rel = 7'(idx_q - csrf_pkg::OFS_WORDS);
      curByte = wordByte(words[rel[4:1]], rel[0]);
    end else if (idx_q < csrf_pkg::OFS_NAME) begin
      rel = 7'(idx_q - csrf_pkg::OFS_SEF_RATIO);
      curByte = wordByte(settings.sefCurrentTransformerRatio, rel[0]);
    end else if (idx_q < csrf_pkg::OFS_OCI) begin
      rel = 7'(idx_q - csrf_pkg::OFS_NAME);
      curByte = strByte(settings.unitName, rel, 7'(csrf_pkg::NAME_LEN));
    end else if (idx_q == csrf_pkg::OFS_OCI) begin
      curByte = ociClean;
    end else if (idx_q < csrf_pkg::OFS_SPARE) begin
      rel = 7'(idx_q - csrf_pkg::OFS_RESID_RATIO);
      curByte = wordByte(settings.residualVoltageTransformerRatio, rel[0]);
    end else if (idx_q < csrf_pkg::OFS_CONTRAST) begin
      curByte = csrf_pkg::SPARE_FILL;
    end else if (idx_q < csrf_pkg::OFS_RELAY_PW) begin
      rel = 7'(idx_q - csrf_pkg::OFS_CONTRAST);
      curByte = wordByte(settings.displayContrast, rel[0]);
    end else if (idx_q < csrf_pkg::OFS_TEST_PW) begin
      rel = 7'(idx_q - csrf_pkg::OFS_RELAY_PW);
      curByte = strByte({88'h0, settings.relayPassword}, rel, 7'(csrf_pkg::PW_LEN));
    end else if (idx_q < csrf_pkg::OFS_CHECKSUM) begin
      rel = 7'(idx_q - csrf_pkg::OFS_TEST_PW);
      curByte = strByte({88'h0, settings.testPassword}, rel, 7'(csrf_pkg::PW_LEN));
    end else begin
      rel = 7'(idx_q - csrf_pkg::OFS_CHECKSUM);
      curByte = wordByte(ckSum, rel[0]);
    end
  end

  // Beat accepted when a valid byte meets ready
  assign beatTaken = out_q.valid && txReady;
  assign idx_d = 7'(idx_q + 7'h01);

  csrf_checksum uChecksum (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ckMode(ckMode),
    .clear(state_q == ST_IDLE),
    .take(state_q == ST_SEND && idx_q < csrf_pkg::OFS_CHECKSUM),
    .dataIn(curByte),
    .sum(ckSum)
  );

  // Sequencer: one byte loaded per SEND, held until accepted
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      idx_q <= csrf_pkg::IDX_RESET;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          idx_q <= csrf_pkg::IDX_RESET;
          if (startReq) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (beatTaken) begin
            if (idx_q == csrf_pkg::OFS_LAST) begin
              state_q <= ST_IDLE;
            end else begin
              idx_q <= idx_d;
              state_q <= ST_SEND;
            end
          end
        end
      endcase
    end
  end

  // Status snapshot at request so byte 1/1 is coherent
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status_q <= 8'h00;
    end else if (state_q == ST_IDLE && startReq) begin
      status_q <= relayStatus;
    end
  end

  // Output byte register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      out_q <= '0;
    end else if (state_q == ST_SEND) begin
      out_q.valid <= 1'b1;
      out_q.data <= curByte;
      out_q.first <= (idx_q == csrf_pkg::OFS_STATUS);
      out_q.last <= (idx_q == csrf_pkg::OFS_LAST);
    end else if (beatTaken) begin
      out_q <= '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      busy_q <= startReq;
    end else if (state_q == ST_WAIT && beatTaken && idx_q == csrf_pkg::OFS_LAST) begin
      busy_q <= 1'b0;
    end
  end

  assign txByte = out_q;
  assign busy = busy_q;

endmodule
`default_nettype wire

// [csrf_framer_asserts.sv]
// Checker for the reply framer ports: handshake, framing, fixed bytes.
// Assumes it is bound onto csrf_framer; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module csrf_framer_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Inputs
  input wire logic startReq,
  input wire logic [7:0] relayStatus,
  input wire logic [1:0] ckMode,
  input wire csrf_pkg::csrf_settings_t settings,
  input wire logic txReady,
  // Outputs
  input wire csrf_pkg::csrf_byte_t txByte,
  input wire logic busy
);
  logic [6:0] byteIdx_q;
  logic take;
  assign take = txByte.valid && txReady;
  // Position of the byte on offer
  always_ff @(posedge mclk) begin
    if (sys_rst || (take && txByte.last)) begin
      byteIdx_q <= 7'h00;
    end else if (take) begin
      byteIdx_q <= byteIdx_q + 7'h01;
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  property p_hold;
    txByte.valid && !txReady |=> txByte.valid && $stable(txByte);
  endproperty
  a_hold: assert property (p_hold) else $error("byte changed before accept");
  property p_gap;
    take |=> !txByte.valid;
  endproperty
  a_gap: assert property (p_gap) else $error("valid not dropped after accept");
  property p_start;
    !busy && startReq |=> busy ##1 (txByte.valid && txByte.first
      && txByte.data == $past(relayStatus, 2));
  endproperty
  a_start: assert property (p_start) else $error("first byte not status");
  property p_code;
    take && txByte.first |=> !txByte.valid ##1 (txByte.valid && txByte.data == 8'h4B);
  endproperty
  a_code: assert property (p_code) else $error("reply code wrong");
  property p_total;
    txByte.valid && byteIdx_q == 7'h02 |-> txByte.data == 8'h17;
  endproperty
  a_total: assert property (p_total) else $error("message count wrong");
  property p_flag;
    txByte.valid && byteIdx_q == 7'h1B |-> !txByte.data[3] && !txByte.data[7];
  endproperty
  a_flag: assert property (p_flag) else $error("reserved flag bit set");
  property p_oci;
    txByte.valid && byteIdx_q == 7'h34 |-> txByte.data[7:2] == 6'h00;
  endproperty
  a_oci: assert property (p_oci) else $error("button byte reserved bits set");
  property p_spare;
    txByte.valid && (byteIdx_q == 7'h37 || byteIdx_q == 7'h38) |-> txByte.data == 8'h00;
  endproperty
  a_spare: assert property (p_spare) else $error("spare byte not zero");
  property p_last;
    txByte.valid && txByte.last |-> byteIdx_q == 7'h44;
  endproperty
  a_last: assert property (p_last) else $error("last byte misplaced");
  property p_end;
    take && txByte.last |=> !busy && !txByte.valid;
  endproperty
  a_end: assert property (p_end) else $error("busy after last byte");
  property p_name;
    txByte.valid && byteIdx_q == 7'h25 |-> txByte.data == settings.unitName[119:112];
  endproperty
  a_name: assert property (p_name) else $error("name character 1 wrong");
  property p_pw;
    txByte.valid && byteIdx_q == 7'h3F |-> txByte.data == settings.testPassword[31:24];
  endproperty
  a_pw: assert property (p_pw) else $error("test password character 1 wrong");
  property p_xor;
    txByte.valid && byteIdx_q == 7'h43 && ckMode == 2'h1 |-> txByte.data == 8'h00;
  endproperty
  a_xor: assert property (p_xor) else $error("xor checksum high byte not zero");
endmodule
bind csrf_framer csrf_framer_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .startReq(startReq), .relayStatus(relayStatus), .ckMode(ckMode), .settings(settings),
  .txReady(txReady), .txByte(txByte), .busy(busy));
`default_nettype wire

// [csrf_sink.sv]
// Host side model: paces txReady and records accepted reply bytes.
// Assumes one clock shared with the framer.
`timescale 1ns/1ns
`default_nettype none
module csrf_sink (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Pace and stream
  input wire logic slow,
  input wire csrf_pkg::csrf_byte_t txByte,
  output logic txReady,
  // Record
  output var logic [7:0] got [0:68],
  output var int n
);
  logic [1:0] pace_q;
  // Slow mode accepts one beat in three to stretch each hold
  assign txReady = !slow || (pace_q == 2'h2);
  always_ff @(posedge mclk) begin
    if (sys_rst || pace_q == 2'h2) begin
      pace_q <= 2'h0;
    end else begin
      pace_q <= pace_q + 2'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (txByte.valid && txReady) begin
      got[txByte.first ? 0 : n] <= txByte.data;
      n <= txByte.first ? 1 : n + 1;
    end
  end
endmodule
`default_nettype wire

// [csrf_framer_tb_top.sv]
// Testbench for the reply framer: loads settings, runs replies, checks bytes.
// Assumes the sink model records each accepted byte.
`timescale 1ns/1ns
`default_nettype none
module csrf_framer_tb_top;
  logic mclk, sys_rst, startReq, slow, txReady, busy;
  logic [7:0] relayStatus;
  logic [1:0] ckMode;
  csrf_pkg::csrf_settings_t settings;
  csrf_pkg::csrf_byte_t txByte;
  logic [7:0] got [0:68];
  logic [7:0] exp [0:68];
  int n, n_mismatch, num_checks, cyc;
  csrf_framer dut (.mclk(mclk), .sys_rst(sys_rst), .startReq(startReq),
    .relayStatus(relayStatus), .ckMode(ckMode), .settings(settings),
    .txReady(txReady), .txByte(txByte), .busy(busy));
  csrf_sink sink (.mclk(mclk), .sys_rst(sys_rst), .slow(slow), .txByte(txByte),
    .txReady(txReady), .got(got), .n(n));
  task automatic close_out;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Reserved bits are loaded as ones so forcing shows
  task automatic build(input logic [7:0] seed, input logic [1:0] md, input logic sl);
    logic [7:0] b;
    logic [15:0] sum;
    logic [7:0] x;
    int p;
    @(posedge mclk);
    relayStatus <= seed ^ 8'h5A;
    ckMode <= md;
    slow <= sl;
    exp[0] = seed ^ 8'h5A;
    exp[1] = 8'h4B;
    exp[2] = 8'h17;
    exp[55] = 8'h00;
    exp[56] = 8'h00;
    for (int k = 0; k < 62; k++) begin
      b = (k == 24 || k == 49) ? 8'hFF : seed + 8'h0B * k[7:0];
      settings[495 - 8 * k -: 8] <= b;
      p = (k < 52) ? k + 3 : k + 5;
      exp[p] = (k == 24) ? (b & 8'h77) : (k == 49) ? (b & 8'h03) : b;
    end
    sum = 16'h0000;
    x = 8'h00;
    for (int i = 0; i < 67; i++) begin
      sum = sum + {8'h00, exp[i]};
      x = x ^ exp[i];
    end
    exp[67] = (md == 2'h1) ? 8'h00 : sum[15:8];
    exp[68] = (md == 2'h1) ? x : sum[7:0];
  endtask
  task automatic run_reply(input int hold);
    @(posedge mclk);
    startReq <= 1'b1;
    repeat (hold) @(posedge mclk);
    startReq <= 1'b0;
    @(negedge mclk);
    chk(busy, 1'b1);
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
      @(negedge mclk);
    end
    chk(busy, 1'b0);
    chk(n[15:0], 16'h0045);
    for (int i = 0; i < 67; i++) begin
      chk(got[i], exp[i]);
    end
    chk(got[67], exp[67]);
    chk(got[68], exp[68]);
  endtask
  task automatic t_sum_prompt;
    build(8'h21, 2'h0, 1'b0);
    run_reply(1);
  endtask
  // Stalled sink; start held high while busy must not restart
  task automatic t_xor_slow;
    build(8'hC4, 2'h1, 1'b1);
    run_reply(20);
    repeat (4) @(negedge mclk);
    chk(busy, 1'b0);
  endtask
  task automatic t_back_to_back;
    build(8'h77, 2'h2, 1'b0);
    run_reply(1);
    build(8'h0E, 2'h3, 1'b0);
    run_reply(1);
  endtask
  task automatic t_reset_mid;
    build(8'h99, 2'h0, 1'b1);
    @(posedge mclk);
    startReq <= 1'b1;
    @(posedge mclk);
    startReq <= 1'b0;
    repeat (30) @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk(busy, 1'b0);
    chk(txByte.valid, 1'b0);
    @(posedge mclk);
    sys_rst <= 1'b0;
    build(8'h3C, 2'h0, 1'b1);
    run_reply(1);
  endtask
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    sys_rst = 1'b1;
    startReq = 1'b0;
    slow = 1'b0;
    relayStatus = 8'h00;
    ckMode = 2'h0;
    settings = '0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    t_sum_prompt();
    t_xor_slow();
    t_back_to_back();
    t_reset_mid();
    close_out();
  end
endmodule
`default_nettype wire
